// file: hdl/opaddr_pkg.sv
// Types of the operand and effective-address generator.
// Assumes opaddr_regs.svh supplies the numeric constants.
package opaddr_pkg;
    typedef enum logic [3:0] {
        MODE_REG,
        MODE_DIRECT,
        MODE_DIRECT_IDX,
        MODE_IMM_LONG,
        MODE_IMM_LONG_IDX,
        immediate_short_positive,
        immediate_short_negative,
        counter_relative_mode,
        MODE_BASE,
        MODE_BASE_IDX,
        MODE_SPECIAL
    } addr_mode_t;
endpackage : opaddr_pkg

// file: hdl/opaddr_regs.svh
// Constants of the operand and effective-address generator.
// Assumes a 16-bit word machine with sixteen general registers.
`ifndef OPADDR_REGS_SVH
`define OPADDR_REGS_SVH
`define OPA_BASE_OFFSET   4'hc
`define OPA_PC_STEP       16'h0002
`define OPA_ZERO_REG      4'h0
`define OPA_SHORT_OSC     4'h5
`define OPA_LONG_OSC      4'h6
`define OPA_MEMORY_INCREMENT_OP_OPCODE   8'ha3
`define OPA_MEMORY_INCREMENT_OP_MEM      4'h4
`define OPA_MEMORY_INCREMENT_OP_SHORT    4'h1
`define OPA_IMM_HI        3
`define OPA_REG_LO        4
`define OPA_REG_HI        7
`define OPA_DISP_HI       7
`define OPA_BASE_LO       8
`define OPA_BASE_HI       9
`endif

// file: hdl/operand_address_generation.sv
// Forms operands and effective addresses from decoded instruction fields.
// Assumes the decoder supplies mode and fields, and the register file
// answers two combinational reads in the same cycle.
`timescale 1ns/100ps
`include "opaddr_regs.svh"
`default_nettype none
module operand_address_generation (
    // Clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      rstn_i,
    // Instruction fields
    input  wire logic                      req_i,
    input  wire opaddr_pkg::addr_mode_t    mode_i,
    input  wire logic [7:0]                opcode_i,
    input  wire logic [15:0]               instr_i,
    input  wire logic [15:0]               addr_field_i,
    input  wire logic [15:0]               instruction_counter_i,
    input  wire logic                      branch_taken_i,
    // Register file reads
    output logic      [3:0]                index_sel_o,
    output logic      [3:0]                base_register_select_o,
    input  wire logic [15:0]               index_data_i,
    input  wire logic [15:0]               base_data_i,
    // Memory address path
    output logic                           fetch_req_o,
    output var opaddr_pkg::addr_mode_t     mode_o,
    output logic [15:0]                    eff_addr_o,
    output logic [15:0]                    operand_o,
    output logic                           operand_valid_o,
    output logic                           branch_o,
    output logic                           special_o,
    output logic                           illegal_reg_o,
    // Cycle cost
    output logic [3:0]                     mem_cycles_o,
    output logic [3:0]                     short_cycles_o,
    output logic [3:0]                     short_osc_o,
    output logic [3:0]                     long_osc_o
);

    // Register number field, shared by index and register forms
    function automatic logic [3:0] reg_field(input logic [15:0] ins);
        reg_field = ins[`OPA_REG_HI:`OPA_REG_LO];
    endfunction : reg_field

    // Direct forms, plain or indexed
    function automatic logic is_direct(input opaddr_pkg::addr_mode_t m);
        is_direct = (m == opaddr_pkg::MODE_DIRECT)
                 || (m == opaddr_pkg::MODE_DIRECT_IDX);
    endfunction : is_direct

    // Modes whose operand sits in memory
    function automatic logic needs_fetch(input opaddr_pkg::addr_mode_t m);
        needs_fetch = is_direct(m) || (m == opaddr_pkg::MODE_BASE)
                   || (m == opaddr_pkg::MODE_BASE_IDX);
    endfunction : needs_fetch

    logic [3:0]  imm_raw;
    logic [7:0]  disp_raw;
    logic [1:0]  base_field_raw;
    logic [15:0] unsigned_displacement;
    logic [15:0] short_mag;
    logic        idx_nz;

    assign imm_raw        = instr_i[`OPA_IMM_HI:0];
    assign disp_raw       = instr_i[`OPA_DISP_HI:0];
    assign base_field_raw = instr_i[`OPA_BASE_HI:`OPA_BASE_LO];
    assign unsigned_displacement = {8'h00, disp_raw};
    // Field value 0 encodes 1, value 15 encodes 16
    assign short_mag = {12'h000, imm_raw} + 16'h0001;
    assign idx_nz    = reg_field(instr_i) != `OPA_ZERO_REG;

    assign index_sel_o = reg_field(instr_i);
    assign base_register_select_o =
        {2'b00, base_field_raw} + `OPA_BASE_OFFSET;

    logic                   fetch_d, fetch_q;
    opaddr_pkg::addr_mode_t mode_d, mode_q;
    logic [15:0]            ea_d, ea_q, opnd_d, opnd_q;
    logic                   ov_d, ov_q, br_d, br_q, sp_d, sp_q;
    logic                   ill_d, ill_q;
    logic [3:0]             mc_d, mc_q, sc_d, sc_q;

    always_comb begin
        fetch_d = 1'b0;
        mode_d  = mode_q;
        ea_d    = ea_q;
        opnd_d  = opnd_q;
        ov_d    = 1'b0;
        br_d    = 1'b0;
        sp_d    = 1'b0;
        ill_d   = 1'b0;
        mc_d    = mc_q;
        sc_d    = sc_q;
        if (req_i) begin
            mode_d  = mode_i;
            ea_d    = 16'h0000;
            opnd_d  = 16'h0000;
            mc_d    = 4'h0;
            sc_d    = 4'h0;
            unique case (mode_i)
                opaddr_pkg::MODE_REG: begin
                    ov_d = 1'b0;
                end
                opaddr_pkg::MODE_DIRECT: begin
                    ea_d    = addr_field_i;
                    fetch_d = 1'b1;
                end
                opaddr_pkg::MODE_DIRECT_IDX: begin
                    // Register 0 cannot index
                    ill_d   = !idx_nz;
                    ea_d    = index_data_i + addr_field_i;
                    fetch_d = 1'b1;
                end
                opaddr_pkg::MODE_IMM_LONG: begin
                    opnd_d = addr_field_i;
                    ov_d   = 1'b1;
                end
                opaddr_pkg::MODE_IMM_LONG_IDX: begin
                    opnd_d = idx_nz ? index_data_i + addr_field_i
                                    : addr_field_i;
                    ov_d   = 1'b1;
                end
                opaddr_pkg::immediate_short_positive: begin
                    opnd_d = short_mag;
                    ov_d   = 1'b1;
                end
                opaddr_pkg::immediate_short_negative: begin
                    opnd_d = 16'h0000 - short_mag;
                    ov_d   = 1'b1;
                end
                opaddr_pkg::counter_relative_mode: begin
                    // Only the single-word branch form reaches here
                    ea_d = instruction_counter_i - `OPA_PC_STEP
                         + {{8{disp_raw[7]}}, disp_raw};
                    br_d = branch_taken_i;
                end
                opaddr_pkg::MODE_BASE: begin
                    ea_d    = base_data_i + unsigned_displacement;
                    fetch_d = 1'b1;
                end
                opaddr_pkg::MODE_BASE_IDX: begin
                    ill_d   = !idx_nz;
                    ea_d    = index_data_i + base_data_i;
                    fetch_d = 1'b1;
                end
                default: begin
                    sp_d = 1'b1;
                end
            endcase
            // Cost only for the direct forms of the increment op
            if (opcode_i == `OPA_MEMORY_INCREMENT_OP_OPCODE && is_direct(mode_i)) begin
                mc_d = `OPA_MEMORY_INCREMENT_OP_MEM;
                sc_d = `OPA_MEMORY_INCREMENT_OP_SHORT;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fetch_q <= 1'b0;
            mode_q  <= opaddr_pkg::MODE_SPECIAL;
            ea_q    <= 16'h0000;
            opnd_q  <= 16'h0000;
            ov_q    <= 1'b0;
            br_q    <= 1'b0;
            sp_q    <= 1'b0;
            ill_q   <= 1'b0;
            mc_q    <= 4'h0;
            sc_q    <= 4'h0;
        end else begin
            fetch_q <= fetch_d;
            mode_q  <= mode_d;
            ea_q    <= ea_d;
            opnd_q  <= opnd_d;
            ov_q    <= ov_d;
            br_q    <= br_d;
            sp_q    <= sp_d;
            ill_q   <= ill_d;
            mc_q    <= mc_d;
            sc_q    <= sc_d;
        end
    end

    // Mode and address leave together with the fetch strobe
    assign fetch_req_o     = fetch_q;
    assign mode_o          = mode_q;
    assign eff_addr_o      = ea_q;
    assign operand_o       = opnd_q;
    assign operand_valid_o = ov_q;
    assign branch_o        = br_q;
    assign special_o       = sp_q;
    assign illegal_reg_o   = ill_q;
    assign mem_cycles_o    = mc_q;
    assign short_cycles_o  = sc_q;
    assign short_osc_o     = `OPA_SHORT_OSC;
    assign long_osc_o      = `OPA_LONG_OSC;

    a_isp_value: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::immediate_short_positive
        |=> operand_valid_o && operand_o == $past(short_mag)
            && operand_o >= 16'h0001 && operand_o <= 16'h0010)
        else $error("short positive operand out of range");

    a_isn_value: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::immediate_short_negative
        |=> operand_valid_o && operand_o[15]
            && (16'h0000 - operand_o) == {12'h000, $past(imm_raw)} + 16'h0001)
        else $error("short negative operand wrong");

    a_icr_target: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::counter_relative_mode
        |=> eff_addr_o == $past(instruction_counter_i) - 16'h0002
            + {{8{$past(disp_raw[7])}}, $past(disp_raw)}
            && branch_o == $past(branch_taken_i) && !fetch_req_o)
        else $error("branch target wrong");

    a_base_addr: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::MODE_BASE
        |=> fetch_req_o
            && eff_addr_o == $past(base_data_i) + {8'h00, $past(disp_raw)})
        else $error("base address wrong");

    a_base_sel: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        base_register_select_o >= 4'hc
        && base_register_select_o == {2'b11, base_field_raw})
        else $error("base register out of range");

    a_base_idx: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::MODE_BASE_IDX
        |=> eff_addr_o == $past(index_data_i) + $past(base_data_i)
            && illegal_reg_o == ($past(index_sel_o) == 4'h0))
        else $error("indexed base address wrong");

    a_special: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::MODE_SPECIAL
        |=> special_o && !fetch_req_o && !operand_valid_o)
        else $error("special mode not flagged");

    a_memory_increment_op_cost: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && opcode_i == 8'ha3 && is_direct(mode_i)
        |=> mem_cycles_o == 4'h4 && short_cycles_o == 4'h1
            && short_osc_o == 4'h5 && long_osc_o == 4'h6)
        else $error("increment cost wrong");

    a_cost_other: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && !(opcode_i == 8'ha3 && is_direct(mode_i))
        |=> mem_cycles_o == 4'h0 && short_cycles_o == 4'h0)
        else $error("cost reported for other instruction");

    a_imm_idx: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::MODE_IMM_LONG_IDX
        |=> operand_o == ($past(index_sel_o) != 4'h0
            ? $past(index_data_i) + $past(addr_field_i)
            : $past(addr_field_i)))
        else $error("long immediate wrong");

    a_imm_long: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::MODE_IMM_LONG
        |=> operand_valid_o && operand_o == $past(addr_field_i))
        else $error("plain long immediate wrong");

    a_dx_addr: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::MODE_DIRECT_IDX
        |=> fetch_req_o && mode_o == opaddr_pkg::MODE_DIRECT_IDX
            && eff_addr_o == $past(index_data_i) + $past(addr_field_i))
        else $error("indexed direct wrong");

    a_dx_illegal: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        req_i && mode_i == opaddr_pkg::MODE_DIRECT_IDX
        |=> illegal_reg_o == ($past(index_sel_o) == 4'h0))
        else $error("indexed direct register 0 not flagged");

    // Operand fetch: a memory-mode request, then a lone fetch strobe
    sequence s_fetch_issue;
        req_i && needs_fetch(mode_i);
    endsequence

    sequence s_fetch_answer;
        fetch_req_o && !operand_valid_o && !branch_o && !special_o;
    endsequence

    // No pulse output stands without a request one cycle before
    sequence s_quiet;
        !fetch_req_o && !operand_valid_o && !branch_o
        && !special_o && !illegal_reg_o;
    endsequence

    a_fetch_strobe: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        s_fetch_issue |=> s_fetch_answer)
        else $error("fetch strobe missing");

    a_idle_quiet: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !req_i |=> s_quiet)
        else $error("pulse output without request");

    a_hold_result: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !req_i |=> $stable(eff_addr_o) && $stable(operand_o)
            && $stable(mode_o))
        else $error("result changed without request");

endmodule : operand_address_generation
`default_nettype wire

// file: verif/operand_address_generation_test.sv
// Self-checking bench of the operand and address generator.
// Assumes regfile_model answers reads with {n, 12'h0f0}.
`timescale 1ns/100ps
`default_nettype none
module operand_address_generation_test;
    logic                   clk_sys_i, rstn_i, req_i, taken;
    opaddr_pkg::addr_mode_t mode_i, mode_o;
    logic [7:0]             opcode_i;
    logic [15:0]            instr_i, addr_i, ic_i, idx_d, base_d, ea, opnd;
    logic [3:0]             idx_s, base_s, mcyc, scyc, sosc, losc;
    logic                   fetch, opv, branch, special, illegal;
    int                     mismatches, checks_done, cycles;

    operand_address_generation uut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req_i),
        .mode_i(mode_i), .opcode_i(opcode_i), .instr_i(instr_i),
        .addr_field_i(addr_i), .instruction_counter_i(ic_i),
        .branch_taken_i(taken), .index_sel_o(idx_s),
        .base_register_select_o(base_s), .index_data_i(idx_d),
        .base_data_i(base_d), .fetch_req_o(fetch), .mode_o(mode_o),
        .eff_addr_o(ea), .operand_o(opnd), .operand_valid_o(opv),
        .branch_o(branch), .special_o(special), .illegal_reg_o(illegal),
        .mem_cycles_o(mcyc), .short_cycles_o(scyc), .short_osc_o(sosc),
        .long_osc_o(losc));
    regfile_model far (.index_sel_i(idx_s), .base_sel_i(base_s),
        .index_data_o(idx_d), .base_data_o(base_d));

    task automatic finish_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    // Request held high across calls, so back-to-back issues work
    task automatic issue(input opaddr_pkg::addr_mode_t m,
                         input logic [15:0] ins, input logic [15:0] a);
        mode_i  = m;
        instr_i = ins;
        addr_i  = a;
        req_i   = 1'b1;
        @(posedge clk_sys_i);
        #1;
    endtask : issue

    task automatic idle;
        req_i = 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask : idle

    task automatic t_short;
        for (int n = 0; n < 16; n++) begin
            issue(opaddr_pkg::immediate_short_positive, 16'(n), 16'h0000);
            chk("isp", 16'(n + 1), opnd);
            chk("isp_valid", 16'h0001, {15'h0, opv});
            issue(opaddr_pkg::immediate_short_negative, 16'(n), 16'h0000);
            chk("isn", 16'(-(n + 1)), opnd);
        end
        idle;
        chk("valid_drop", 16'h0000, {15'h0, opv});
    endtask : t_short

    task automatic t_branch;
        ic_i  = 16'h0001;
        taken = 1'b1;
        issue(opaddr_pkg::counter_relative_mode, 16'h0080, 16'h0000);
        chk("icr_ea", 16'hff7f, ea);
        chk("taken", 16'h0001, {15'h0, branch});
        taken = 1'b0;
        issue(opaddr_pkg::counter_relative_mode, 16'h007f, 16'h0000);
        chk("not_taken", 16'h0000, {15'h0, branch});
        chk("icr_fwd", 16'h007e, ea);
    endtask : t_branch

    task automatic t_base;
        for (int b = 0; b < 4; b++) begin
            issue(opaddr_pkg::MODE_BASE, 16'(b * 256 + 255), 16'h0000);
            chk("base_sel", 16'(b + 12), {12'h0, base_s});
            chk("base_ea", {4'(b + 12), 12'h0f0} + 16'h00ff, ea);
            chk("fetch", 16'h0001, {15'h0, fetch});
            chk("mode", 16'(opaddr_pkg::MODE_BASE), 16'(mode_o));
        end
        issue(opaddr_pkg::MODE_BASE_IDX, 16'h03f0, 16'h0000);
        chk("bx_wrap", 16'he1e0, ea);
        chk("bx_legal", 16'h0000, {15'h0, illegal});
        issue(opaddr_pkg::MODE_BASE_IDX, 16'h0010, 16'h0000);
        chk("bx_ea", 16'hd1e0, ea);
        issue(opaddr_pkg::MODE_BASE_IDX, 16'h0000, 16'h0000);
        chk("bx_r0", 16'h0001, {15'h0, illegal});
        idle;
        chk("fetch_drop", 16'h0000, {15'h0, fetch});
    endtask : t_base

    task automatic t_mem;
        issue(opaddr_pkg::MODE_IMM_LONG, 16'h0050, 16'h5678);
        chk("im", 16'h5678, opnd);
        chk("im_valid", 16'h0001, {15'h0, opv});
        issue(opaddr_pkg::MODE_IMM_LONG_IDX, 16'h0050, 16'h1234);
        chk("imx", 16'h6324, opnd);
        issue(opaddr_pkg::MODE_IMM_LONG_IDX, 16'h0000, 16'h1234);
        chk("imx_r0", 16'h1234, opnd);
        opcode_i = 8'ha3;
        issue(opaddr_pkg::MODE_DIRECT_IDX, 16'h0020, 16'h0100);
        chk("dx", 16'h21f0, ea);
        chk("memory_increment_op_mem", 16'h0004, {12'h0, mcyc});
        chk("memory_increment_op_short", 16'h0001, {12'h0, scyc});
        issue(opaddr_pkg::MODE_DIRECT, 16'h0000, 16'h4321);
        chk("d", 16'h4321, ea);
        chk("memory_increment_op_d", 16'h0004, {12'h0, mcyc});
        issue(opaddr_pkg::MODE_REG, 16'h0000, 16'h0000);
        chk("memory_increment_op_r", 16'h0000, {12'h0, mcyc});
        chk("reg_mode", 16'(opaddr_pkg::MODE_REG), 16'(mode_o));
        chk("reg_nofetch", 16'h0000, {15'h0, fetch});
        opcode_i = 8'ha2;
        issue(opaddr_pkg::MODE_SPECIAL, 16'h0000, 16'h0000);
        chk("special", 16'h0001, {15'h0, special});
        chk("other_mem", 16'h0000, {12'h0, mcyc});
        chk("short_osc", 16'h0005, {12'h0, sosc});
        chk("long_osc", 16'h0006, {12'h0, losc});
        idle;
        chk("special_drop", 16'h0000, {15'h0, special});
    endtask : t_mem

    // Mid-run reset clears results; first request right after release
    task automatic t_reset;
        issue(opaddr_pkg::MODE_DIRECT_IDX, 16'h0070, 16'h0009);
        chk("idx_sel", 16'h0007, {12'h0, idx_s});
        chk("dx_ea", 16'h70f9, ea);
        issue(opaddr_pkg::MODE_DIRECT_IDX, 16'h0000, 16'h0009);
        chk("dx_r0", 16'h0001, {15'h0, illegal});
        chk("dx_r0_ea", 16'h00f9, ea);
        rstn_i = 1'b0;
        req_i  = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("rst_mode", 16'(opaddr_pkg::MODE_SPECIAL), 16'(mode_o));
        chk("rst_ea", 16'h0000, ea);
        chk("rst_ill", 16'h0000, {15'h0, illegal});
        chk("rst_fetch", 16'h0000, {15'h0, fetch});
        rstn_i = 1'b1;
        issue(opaddr_pkg::MODE_DIRECT, 16'h0000, 16'hbeef);
        chk("first_d", 16'hbeef, ea);
        chk("first_fetch", 16'h0001, {15'h0, fetch});
        idle;
        chk("first_drop", 16'h0000, {15'h0, fetch});
    endtask : t_reset

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // Hang guard: the run needs well under 200 cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            finish_test;
        end
    end

    initial begin
        rstn_i   = 1'b0;
        req_i    = 1'b0;
        taken    = 1'b0;
        mode_i   = opaddr_pkg::MODE_REG;
        opcode_i = 8'h81;
        instr_i  = 16'h0000;
        addr_i   = 16'h0000;
        ic_i     = 16'h0000;
        repeat (8) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        t_short;
        t_branch;
        t_base;
        t_mem;
        t_reset;
        finish_test;
    end
endmodule : operand_address_generation_test
`default_nettype wire

// file: verif/regfile_model.sv
// Register file model for the address generator's two read ports.
// Assumes reads are combinational; register n holds {n, 12'h0f0}.
`timescale 1ns/100ps
`default_nettype none
module regfile_model (
    // Read addresses
    input  wire logic [3:0]  index_sel_i,
    input  wire logic [3:0]  base_sel_i,
    // Read data
    output logic      [15:0] index_data_o,
    output logic      [15:0] base_data_o
);
    assign index_data_o = {index_sel_i, 12'h0f0};
    assign base_data_o  = {base_sel_i, 12'h0f0};
endmodule : regfile_model
`default_nettype wire
